/* File: src/msrc_pkg.sv */
package msrc_pkg;
    // register map, byte addresses on the apb slave
    localparam logic [11:0] MSRC_SOFT_RESET_OFF = 12'h000;
    localparam logic [11:0] MSRC_BYTE_REG8_OFF = 12'h020;
    localparam logic [11:0] MSRC_TDM_CTRL_OFF = 12'h024;
    localparam logic [11:0] MSRC_STATUS_OFF = 12'h028;
    // field positions
    localparam int MSRC_SOFT_RESET_BIT = 3;
    localparam int MSRC_SIDE_BIT = 0;
    localparam int MSRC_MASTER_BIT = 0;
    localparam int MSRC_FREQ_OUT_BIT = 1;
    localparam int MSRC_FMT_LSB = 2;
    // reset values
    localparam logic [7:0] MSRC_SOFT_RESET_RST = 8'h00;
    localparam logic [7:0] MSRC_BYTE_REG8_RST = 8'h00;
    localparam logic [7:0] MSRC_TDM_CTRL_RST = 8'h00;
    // timing: least reset low time, six oscillator periods
    localparam int MSRC_OSC_KHZ = 20480;
    localparam int MSRC_CLK_KHZ = 125000;
    localparam int MSRC_RST_OSC_PERIODS = 6;
    localparam int MSRC_RST_MIN_CYC =
        (MSRC_RST_OSC_PERIODS * MSRC_CLK_KHZ + MSRC_OSC_KHZ - 1) / MSRC_OSC_KHZ;
    // tdm data formats in host mode
    typedef enum logic [1:0] {
        MSRC_FMT_SHORT = 2'b00,
        MSRC_FMT_LONG = 2'b01,
        MSRC_FMT_GCI = 2'b10,
        MSRC_FMT_TSA = 2'b11
    } msrc_fmt_t;
    typedef enum logic [1:0] {
        MSRC_MODE_GCI = 2'b00,
        MSRC_MODE_SER = 2'b01,
        MSRC_MODE_PAR = 2'b10
    } msrc_mode_t;
endpackage

/* File: src/msrc_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - the block holds the device in reset while the reset pin is low and runs when high.
// - bit 3 of the soft reset register acts like the hardware reset pin, except for the line driver and wake-up tone detect.
// - during hardware reset every register returns to its default.
// - in reset as host-mode timing master the data clock and frame sync outputs stop.
// - in hardware reset the line driver goes low impedance and wake-up tone detect is off.
// - side-select input 1 picks network termination, 0 picks line termination unless bit 0 of byte register 8 is set.
// - bit 0 of byte register 8 also picks the side.
// - host/bus select 1 picks host mode with only 2B+D data on the tdm bus.
// - host mode offers four tdm formats: short, long, gci 2B+D and timeslot assigner.
// - host/bus select 0 puts data and control on the tdm bus and frees the port pins.
// - in host mode port-select 1 picks the parallel port and 0 the serial port.
// - the parallel port uses an 8-bit bus and the serial port four signals.
// - frequency pin: 8 kHz input in line mode, enabled output in network host mode.
module msrc_top import msrc_pkg::*; (
    // clock and bus reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire logic line_reset_n,
    input wire logic network_line_side_select,
    input wire logic host_vs_bus_control_select,
    input wire logic register_port_type_select,
    input wire logic tdm_clock_gen,
    input wire logic frame_sync_gen,
    input wire logic freq_ref_gen,
    // decoded mode and reset outputs
    output logic device_reset,
    output logic network_termination_mode,
    output logic line_termination_mode,
    output logic host_mode,
    output logic parallel_register_port,
    output logic serial_register_port,
    output logic serial_port_pins_repurposed,
    output logic [1:0] tdm_format,
    output logic [3:0] port_bus_width,
    output logic tx_driver_low_z,
    output logic wake_tone_detect_en,
    output logic tdm_data_clock,
    output logic tdm_data_clock_oe,
    output logic receive_frame_sync,
    output logic receive_frame_sync_oe,
    output logic frequency_reference_pin_out,
    output logic frequency_reference_pin_oe
);
    localparam logic [3:0] PAR_WIDTH = 4'h8;
    localparam logic [3:0] SER_SIGNALS = 4'h4;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] side_sync;
        logic [1:0] host_sync;
        logic [1:0] port_sync;
        logic hw_reset;
        logic soft_reset;
        logic side_sw;
        logic master;
        logic freq_out_en;
        logic [1:0] fmt;
        logic [31:0] rdata;
        logic [7:0] low_cnt;
        logic short_pulse;
    } msrc_state_t;

    msrc_state_t st_r, st_nxt;

    logic access;
    logic any_reset;
    logic nt;
    logic host;
    logic par;

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h000000, b};
    endfunction

    // one decode shared by the error flag and the read mux
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = a == MSRC_SOFT_RESET_OFF || a == MSRC_BYTE_REG8_OFF ||
            a == MSRC_TDM_CTRL_OFF || a == MSRC_STATUS_OFF;
    endfunction

    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !reg_hit(paddr);
    assign prdata = st_r.rdata;

    assign any_reset = st_r.hw_reset || st_r.soft_reset;
    // software side bit or strap; either one set picks network side
    assign nt = st_r.side_sync[1] || st_r.side_sync[1] == 1'b0 && st_r.side_sw;
    assign host = st_r.host_sync[1];
    assign par = host && st_r.port_sync[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], line_reset_n};
        st_nxt.side_sync = {st_r.side_sync[0], network_line_side_select};
        st_nxt.host_sync = {st_r.host_sync[0], host_vs_bus_control_select};
        st_nxt.port_sync = {st_r.port_sync[0], register_port_type_select};
        st_nxt.hw_reset = !st_r.rst_sync[1];
        // low-time counter flags pulses shorter than the valid minimum
        if (!st_r.rst_sync[1]) begin
            if (st_r.low_cnt != 8'hFF) begin
                st_nxt.low_cnt = st_r.low_cnt + 8'h01;
            end
        end else begin
            st_nxt.low_cnt = 8'h00;
        end
        if (st_r.rst_sync[1] && st_r.hw_reset) begin
            st_nxt.short_pulse = (st_r.low_cnt < 8'(MSRC_RST_MIN_CYC));
        end
        st_nxt.rdata = 32'h00000000;
        // read data is valid for the access cycle only, zero otherwise
        if (psel && !penable && !pwrite && reg_hit(paddr)) begin
            case (paddr)
                MSRC_SOFT_RESET_OFF: begin
                    st_nxt.rdata = byte_word({4'h0, st_r.soft_reset, 3'h0});
                end
                MSRC_BYTE_REG8_OFF: begin
                    st_nxt.rdata = byte_word({7'h00, st_r.side_sw});
                end
                MSRC_TDM_CTRL_OFF: begin
                    st_nxt.rdata = byte_word({4'h0, st_r.fmt, st_r.freq_out_en, st_r.master});
                end
                MSRC_STATUS_OFF: begin
                    st_nxt.rdata = byte_word({1'b0, st_r.short_pulse, any_reset, par,
                        host && !par, host, !nt, nt});
                end
                default: begin
                    st_nxt.rdata = 32'h00000000;
                end
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                MSRC_SOFT_RESET_OFF: begin
                    st_nxt.soft_reset = pwdata[MSRC_SOFT_RESET_BIT];
                end
                MSRC_BYTE_REG8_OFF: begin
                    st_nxt.side_sw = pwdata[MSRC_SIDE_BIT];
                end
                MSRC_TDM_CTRL_OFF: begin
                    st_nxt.master = pwdata[MSRC_MASTER_BIT];
                    st_nxt.freq_out_en = pwdata[MSRC_FREQ_OUT_BIT];
                    st_nxt.fmt = pwdata[MSRC_FMT_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        // control registers held at default while in reset; soft bit survives soft reset
        if (st_r.hw_reset) begin
            st_nxt.soft_reset = MSRC_SOFT_RESET_RST[MSRC_SOFT_RESET_BIT];
            st_nxt.side_sw = MSRC_BYTE_REG8_RST[MSRC_SIDE_BIT];
            st_nxt.master = MSRC_TDM_CTRL_RST[MSRC_MASTER_BIT];
            st_nxt.freq_out_en = MSRC_TDM_CTRL_RST[MSRC_FREQ_OUT_BIT];
            st_nxt.fmt = MSRC_TDM_CTRL_RST[MSRC_FMT_LSB +: 2];
        end else if (st_r.soft_reset) begin
            st_nxt.side_sw = MSRC_BYTE_REG8_RST[MSRC_SIDE_BIT];
            st_nxt.master = MSRC_TDM_CTRL_RST[MSRC_MASTER_BIT];
            st_nxt.freq_out_en = MSRC_TDM_CTRL_RST[MSRC_FREQ_OUT_BIT];
            st_nxt.fmt = MSRC_TDM_CTRL_RST[MSRC_FMT_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.hw_reset <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign device_reset = any_reset;
    assign network_termination_mode = nt;
    assign line_termination_mode = !nt;
    assign host_mode = host;
    assign parallel_register_port = par;
    assign serial_register_port = host && !par;
    assign serial_port_pins_repurposed = !host;
    assign tdm_format = host ? st_r.fmt : MSRC_FMT_GCI;
    assign port_bus_width = par ? PAR_WIDTH : SER_SIGNALS;
    assign tx_driver_low_z = st_r.hw_reset;
    assign wake_tone_detect_en = !st_r.hw_reset;
    // master outputs halted low in reset; enables follow the master bit, which both resets clear to 0
    assign tdm_data_clock_oe = host && st_r.master;
    assign receive_frame_sync_oe = host && st_r.master;
    assign tdm_data_clock = tdm_data_clock_oe && !any_reset && tdm_clock_gen;
    assign receive_frame_sync = receive_frame_sync_oe && !any_reset && frame_sync_gen;
    assign frequency_reference_pin_oe = nt && host && st_r.freq_out_en;
    assign frequency_reference_pin_out = frequency_reference_pin_oe && freq_ref_gen;

    hw_reset_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.rst_sync[1] |=> st_r.hw_reset) else $error("reset pin not followed");
    soft_reset_eq_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.soft_reset |-> device_reset) else $error("soft reset ignored");
    regs_default_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.hw_reset |=> !st_r.side_sw && !st_r.master && st_r.fmt == 2'b00)
        else $error("registers not defaulted");
    clk_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_reset |-> !tdm_data_clock && !receive_frame_sync) else $error("clock runs");
    line_term_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.hw_reset |-> tx_driver_low_z && !wake_tone_detect_en)
        else $error("line not terminated");
    side_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.side_sync[1]) |-> network_termination_mode)
        else $error("side strap ignored");
    port_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        host_mode && st_r.port_sync[1] |-> parallel_register_port && port_bus_width == 4'h8)
        else $error("port select wrong");
    bus_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        !host_mode |-> serial_port_pins_repurposed && !parallel_register_port &&
        !serial_register_port) else $error("bus mode wrong");
    freq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        line_termination_mode |-> !frequency_reference_pin_oe)
        else $error("freq pin driven in line mode");
    strap_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##3 (host_mode == $past(host_vs_bus_control_select, 2)))
        else $error("strap sync depth");
    side_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##3 (st_r.side_sync[1] == $past(network_line_side_select, 2)))
        else $error("side strap sync depth");
    port_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##3 (st_r.port_sync[1] == $past(register_port_type_select, 2)))
        else $error("port strap sync depth");

    // reset pin and soft reset behaviour
    release_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.rst_sync[1] |=> !st_r.hw_reset)
        else $error("reset pin release missed");
    hw_reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.rst_sync[1] |=> device_reset)
        else $error("device not held in reset");
    soft_defaults_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.soft_reset |=> !st_r.side_sw && !st_r.master && !st_r.freq_out_en)
        else $error("soft reset left registers set");
    bits_default_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.hw_reset |=> !st_r.freq_out_en && !st_r.soft_reset)
        else $error("control bits not defaulted");
    run_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.hw_reset |-> !tx_driver_low_z && wake_tone_detect_en)
        else $error("line held after reset");
    short_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.rst_sync[1]) && st_r.low_cnt < 8'(MSRC_RST_MIN_CYC) |=> st_r.short_pulse)
        else $error("short pulse not flagged");
    pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.rst_sync[1]) && st_r.low_cnt >= 8'(MSRC_RST_MIN_CYC) |=> !st_r.short_pulse)
        else $error("valid pulse flagged short");

    // mode decode
    lt_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.side_sync[1] && !st_r.side_sw |-> line_termination_mode)
        else $error("line side not chosen");
    sw_side_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.side_sw |-> network_termination_mode && !line_termination_mode)
        else $error("software side ignored");
    wr_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == MSRC_BYTE_REG8_OFF && !any_reset && !st_r.hw_reset
        |=> st_r.side_sw == $past(pwdata[MSRC_SIDE_BIT])) else $error("side write lost");
    host_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        host_mode |-> !serial_port_pins_repurposed && (parallel_register_port || serial_register_port))
        else $error("host mode decode wrong");
    fmt_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        host_mode |-> tdm_format == st_r.fmt)
        else $error("format not applied");
    slave_bus_a: assert property (@(posedge pclk) disable iff (!presetn)
        !host_mode |-> !tdm_data_clock_oe && !receive_frame_sync_oe && tdm_format == MSRC_FMT_GCI)
        else $error("bus mode outputs wrong");
    serial_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        host_mode && !st_r.port_sync[1] |-> serial_register_port && port_bus_width == SER_SIGNALS)
        else $error("serial port wrong");
    master_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
        host_mode && st_r.master |-> tdm_data_clock_oe && receive_frame_sync_oe)
        else $error("master outputs not enabled");
    freq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        network_termination_mode && host_mode && st_r.freq_out_en |-> frequency_reference_pin_oe)
        else $error("freq output not enabled");
    freq_bus_a: assert property (@(posedge pclk) disable iff (!presetn)
        !host_mode |-> !frequency_reference_pin_oe)
        else $error("freq pin driven in bus mode");

    // register bus
    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == MSRC_STATUS_OFF |=> prdata[1:0] ==
        {$past(line_termination_mode), $past(network_termination_mode)})
        else $error("status side bits wrong");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> prdata == 32'h00000000)
        else $error("read data not cleared");

    hw_reset_cov: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(st_r.hw_reset));
    soft_reset_cov: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.soft_reset));
    master_cov: cover property (@(posedge pclk) disable iff (!presetn)
        tdm_data_clock_oe && !any_reset);
    freq_cov: cover property (@(posedge pclk) disable iff (!presetn)
        frequency_reference_pin_oe);
    short_cov: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.short_pulse));
endmodule

/* File: testbench/msrc_partner.sv */
`timescale 1ns/1ns
module msrc_partner import msrc_pkg::*; (
    // clock and requests from the bench
    input wire logic pclk,
    input wire logic [1:0] mode_sel,
    input wire logic side_sel,
    input wire logic rst_req,
    // board pins
    output logic line_reset_n,
    output logic network_line_side_select,
    output logic host_vs_bus_control_select,
    output logic register_port_type_select,
    output logic tdm_clock_gen,
    output logic frame_sync_gen,
    output logic freq_ref_gen
);
    int low_cnt = 0;
    logic [2:0] div = 3'h0;
    // a requested pulse is stretched to the legal minimum
    always_ff @(posedge pclk) begin
        div <= div + 3'h1;
        if (rst_req || (low_cnt != 0 && low_cnt < MSRC_RST_MIN_CYC)) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end
    assign line_reset_n = !(rst_req || low_cnt != 0);
    assign network_line_side_select = side_sel;
    assign host_vs_bus_control_select = mode_sel != MSRC_MODE_GCI;
    // port-select can only be high in host mode
    assign register_port_type_select = mode_sel == MSRC_MODE_PAR;
    assign tdm_clock_gen = div[0];
    assign freq_ref_gen = div[1];
    assign frame_sync_gen = div[2];
endmodule

/* File: testbench/msrc_top_test.sv */
`timescale 1ns/1ns
module msrc_top_test import msrc_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic [1:0] mode_sel = 2'h0, tdm_format;
    logic [3:0] port_bus_width;
    logic side_sel = 1'b0, rst_req = 1'b0, e, pready, pslverr, line_reset_n;
    logic network_line_side_select, host_vs_bus_control_select, register_port_type_select;
    logic tdm_clock_gen, frame_sync_gen, freq_ref_gen, device_reset, host_mode;
    logic network_termination_mode, line_termination_mode, parallel_register_port;
    logic serial_register_port, serial_port_pins_repurposed, tx_driver_low_z;
    logic wake_tone_detect_en, tdm_data_clock, tdm_data_clock_oe, receive_frame_sync;
    logic receive_frame_sync_oe, frequency_reference_pin_out, frequency_reference_pin_oe;
    int num_errors = 0, num_checks = 0;
    // mode, side, nt, host, parallel port, serial port, repurposed, width
    logic [11:0] rows [4] = '{12'h014, 12'h7A4, 12'h8C8, 12'hBC8};
    msrc_partner i_msrc_partner (.pclk, .mode_sel, .side_sel, .rst_req, .line_reset_n,
        .network_line_side_select, .host_vs_bus_control_select, .register_port_type_select,
        .tdm_clock_gen, .frame_sync_gen, .freq_ref_gen);
    msrc_top i_msrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .line_reset_n, .network_line_side_select,
        .host_vs_bus_control_select, .register_port_type_select, .tdm_clock_gen,
        .frame_sync_gen, .freq_ref_gen, .device_reset, .network_termination_mode,
        .line_termination_mode, .host_mode, .parallel_register_port, .serial_register_port,
        .serial_port_pins_repurposed, .tdm_format, .port_bus_width, .tx_driver_low_z,
        .wake_tone_detect_en, .tdm_data_clock, .tdm_data_clock_oe, .receive_frame_sync,
        .receive_frame_sync_oe, .frequency_reference_pin_out, .frequency_reference_pin_oe);
    task automatic report_and_stop;
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // starts one edge late so psel never changes twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h00000000);
        chk(q & m, exp);
    endtask
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (device_reset !== lvl && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (6) @(posedge pclk);
        chk(device_reset, 1'b1);
        chk(tx_driver_low_z, 1'b1);
        presetn <= 1'b1;
        wait_rst(1'b0);
        foreach (rows[i]) begin
            mode_sel <= rows[i][11:10];
            side_sel <= rows[i][9];
            repeat (4) @(posedge pclk);
            chk(network_termination_mode, rows[i][8]);
            chk(line_termination_mode, !rows[i][8]);
            chk({host_mode, parallel_register_port, serial_register_port}, rows[i][7:5]);
            chk(serial_port_pins_repurposed, rows[i][4]);
            chk(port_bus_width, rows[i][3:0]);
            chk(receive_frame_sync_oe, 1'b0);
            rd(MSRC_STATUS_OFF, {rows[i][6:5], rows[i][7], !rows[i][8], rows[i][8]},
                32'h1F);
        end
        side_sel <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, MSRC_BYTE_REG8_OFF, 32'h1);
        @(posedge pclk);
        chk(network_termination_mode, 1'b1);
        apb(1'b1, MSRC_BYTE_REG8_OFF, 32'h0);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, MSRC_TDM_CTRL_OFF, 32'(f * 4 + 1));
            @(posedge pclk);
            chk(tdm_format, f[1:0]);
            chk(tdm_data_clock_oe, 1'b1);
            chk(receive_frame_sync_oe, 1'b1);
        end
        mode_sel <= MSRC_MODE_GCI;
        repeat (4) @(posedge pclk);
        chk(tdm_format, MSRC_FMT_GCI);
        mode_sel <= MSRC_MODE_PAR;
        side_sel <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, MSRC_TDM_CTRL_OFF, 32'h3);
        @(posedge pclk);
        chk(frequency_reference_pin_oe, 1'b1);
        chk(frequency_reference_pin_out, freq_ref_gen);
        chk(tdm_data_clock, tdm_clock_gen);
        @(posedge pclk);
        chk(tdm_data_clock, tdm_clock_gen);
        chk(receive_frame_sync, frame_sync_gen);
        side_sel <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(frequency_reference_pin_oe, 1'b0);
        apb(1'b1, MSRC_SOFT_RESET_OFF, 32'h8);
        wait_rst(1'b1);
        chk(tdm_data_clock, 1'b0);
        chk(receive_frame_sync, 1'b0);
        rd(MSRC_STATUS_OFF, 32'h20, 32'h20);
        rd(MSRC_SOFT_RESET_OFF, 32'h8, 32'hFF);
        apb(1'b1, MSRC_BYTE_REG8_OFF, 32'h1);
        rd(MSRC_BYTE_REG8_OFF, 32'h0, 32'hFF);
        apb(1'b1, MSRC_SOFT_RESET_OFF, 32'h0);
        wait_rst(1'b0);
        apb(1'b1, MSRC_TDM_CTRL_OFF, 32'h1);
        @(posedge pclk);
        rst_req <= 1'b1;
        @(posedge pclk);
        rst_req <= 1'b0;
        wait_rst(1'b1);
        chk(tx_driver_low_z, 1'b1);
        chk(wake_tone_detect_en, 1'b0);
        chk(tdm_data_clock, 1'b0);
        wait_rst(1'b0);
        chk(wake_tone_detect_en, 1'b1);
        rd(MSRC_TDM_CTRL_OFF, 32'h0, 32'hFF);
        rd(MSRC_STATUS_OFF, 32'h00, 32'h60);
        rd(12'h010, 32'h0, 32'hFFFFFFFF);
        chk(e, 1'b1);
        report_and_stop;
    end
endmodule
